// ---- include/dsq_map.svh ----
// Register map, field positions, reset values and timing counts of the sequencer
`ifndef DSQ_MAP_SVH
`define DSQ_MAP_SVH

// Clock rate and period
`define DSQ_CLK_HZ 20000000
`define DSQ_CLK_NS 50

// Register byte offsets
`define DSQ_OFF_CTRL 12'h000
`define DSQ_OFF_STATUS 12'h004
`define DSQ_OFF_RESULT 12'h008
`define DSQ_OFF_CLKDIV 12'h00c

// Control fields
`define DSQ_CTRL_MODE_LO 0
`define DSQ_CTRL_MODE_HI 1
`define DSQ_CTRL_RES8 2
`define DSQ_CTRL_START 3
`define DSQ_CTRL_STOP 4

// Status fields
`define DSQ_ST_DONE 0
`define DSQ_ST_BUSY 1
`define DSQ_ST_PRIME_LO 2
`define DSQ_ST_PRIME_HI 3

// Reset values
`define DSQ_RST_CLKDIV 8'h00
`define DSQ_RST_MODE 2'h0

// Modulator samples per conversion, less one, per resolution
`define DSQ_LEN12_M1 12'hfff
`define DSQ_LEN8_M1 12'h0ff
// Full scale per resolution
`define DSQ_MAX12 12'hfff
`define DSQ_MAX8 12'h0ff
// Conversion index at which the decimator is primed
`define DSQ_PRIMED 2'h3

`endif

// ---- include/dsq_pkg.sv ----
// Types shared by the conversion sequencer
package dsq_pkg;
	// Operating modes
	typedef enum logic [1:0] {
		DSQ_SINGLE = 2'h0,
		DSQ_MULTI = 2'h1,
		DSQ_CONT = 2'h2,
		DSQ_TURBO = 2'h3
	} dsq_mode_t;
	// Sequencer states, one-hot
	typedef enum logic [2:0] {
		DSQ_IDLE = 3'h1,
		DSQ_CONV = 3'h2,
		DSQ_HOLD = 3'h4
	} dsq_state_t;
endpackage

// ---- rtl/dsq_decimator.sv ----
// Pipelined decimator turning the modulator bit stream into result words
`timescale 1ns/1ps
`include "dsq_map.svh"
module dsq_decimator (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic mod_bit,
	input wire logic clear,
	input wire logic res8,
	output logic conv_end,
	output logic [11:0] word
);
	logic [11:0] cnt; // Samples taken in this conversion
	logic [11:0] next_cnt;
	logic [12:0] ones; // Ones counted in this conversion
	logic [12:0] next_ones;
	logic [12:0] hist [0:3]; // Last four conversion counts
	logic [12:0] next_hist [0:3];
	logic next_end;
	logic [11:0] next_word;

	// Average of four counts, clipped to full scale
	function automatic logic [11:0] dsq_avg(input logic [12:0] a, input logic [12:0] b,
		input logic [12:0] c, input logic [12:0] d, input logic r8);
		logic [14:0] s;
		logic [11:0] lim;
		s = 15'(a) + 15'(b) + 15'(c) + 15'(d);
		lim = r8 ? `DSQ_MAX8 : `DSQ_MAX12;
		if (s[14:2] > 13'(lim)) begin
			dsq_avg = lim;
		end else begin
			dsq_avg = s[13:2];
		end
	endfunction

	// Count samples and shift the four-deep history
	always_comb begin
		logic [12:0] inc;
		inc = ones + 13'(mod_bit);
		next_cnt = cnt;
		next_ones = ones;
		next_hist = hist;
		next_end = 1'b0;
		next_word = word;
		if (clear) begin
			// Re-prime: forget all earlier samples
			next_cnt = 12'h000;
			next_ones = 13'h0000;
			for (int i = 0; i < 4; i++) begin
				next_hist[i] = 13'h0000;
			end
		end else if (tick) begin
			if (cnt == (res8 ? `DSQ_LEN8_M1 : `DSQ_LEN12_M1)) begin
				// Output depends on last four conversions R4 R14
				next_hist[0] = inc;
				next_hist[1] = hist[0];
				next_hist[2] = hist[1];
				next_hist[3] = hist[2];
				next_word = dsq_avg(inc, hist[0], hist[1], hist[2], res8);
				next_cnt = 12'h000;
				next_ones = 13'h0000;
				next_end = 1'b1;
			end else begin
				next_cnt = cnt + 12'h001;
				next_ones = inc;
			end
		end
	end

	// Register decimator state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 12'h000;
			ones <= 13'h0000;
			for (int i = 0; i < 4; i++) begin
				hist[i] <= 13'h0000;
			end
			conv_end <= 1'b0;
			word <= 12'h000;
		end else begin
			cnt <= next_cnt;
			ones <= next_ones;
			hist <= next_hist;
			conv_end <= next_end;
			word <= next_word;
		end
	end
endmodule

// ---- rtl/dsq_sequencer.sv ----
// Delta-sigma conversion sequencer with APB registers
// Operation
// R1: Four modes: single, multi, continuous, turbo multi
// R2: Start by control bit or trigger input
// R3: Completion sets status and done output
// R4: Results invalid until fourth conversion
// R5: Single: four conversions, result after fourth
// R6: Single: standby again after result read
// R7: Continuous: three-conversion latency, then every conversion
// R8: Avoid input switching in continuous mode
// R9: Multi: re-prime between samples, auto restart
// R10: Completion seen by polling, interrupt, DMA
// R11: Trigger input optional, driven by logic
// R12: Done output usable as interrupt or DMA
// R13: Resolution traded for sample rate
// R14: Decimator sets resolution and sample rate
// R15: Result read clears done; set wins
// R16: Trigger synchronised, rising edge, ignored when busy
`timescale 1ns/1ps
`include "dsq_map.svh"
module dsq_sequencer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mod_bit_in,
	input wire logic start_trig,
	output logic conv_done
);
	// Configuration
	dsq_pkg::dsq_mode_t mode;
	dsq_pkg::dsq_mode_t next_mode;
	logic res8; // Eight-bit resolution select
	logic next_res8;
	logic [7:0] clkdiv; // Modulator tick divider
	logic [7:0] next_clkdiv;
	// Sequencer
	dsq_pkg::dsq_state_t state;
	dsq_pkg::dsq_state_t next_state;
	logic [1:0] prime; // Conversions since last re-prime, held at 3 once primed
	logic [1:0] next_prime;
	logic dec_clear; // Re-prime pulse to decimator
	// Result
	logic [11:0] result;
	logic [11:0] next_result;
	logic done; // Completion flag
	logic next_done;
	// Divider
	logic [7:0] div_cnt;
	logic [7:0] next_div_cnt;
	logic tick;
	// Synchronisers
	logic mod_s1;
	logic mod_s2;
	logic trig_s1;
	logic trig_s2;
	logic trig_s3;
	logic trig_rise;
	// Bus
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic wr_acc;
	logic rd_result;
	logic start_wr;
	logic stop_wr;
	// Decimator
	logic conv_end;
	logic [11:0] dec_word;
	logic res_event; // Valid result this cycle

	// Zero-wait slave
	assign pready = 1'b1;
	assign wr_acc = psel && penable && pwrite;
	assign rd_result = psel && penable && !pwrite && (paddr == `DSQ_OFF_RESULT);
	assign start_wr = wr_acc && (paddr == `DSQ_OFF_CTRL) && pwdata[`DSQ_CTRL_START];
	assign stop_wr = wr_acc && (paddr == `DSQ_OFF_CTRL) && pwdata[`DSQ_CTRL_STOP];

	// Two-stage synchronisers on pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mod_s1 <= 1'b0;
			mod_s2 <= 1'b0;
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_s3 <= 1'b0;
		end else begin
			mod_s1 <= mod_bit_in;
			mod_s2 <= mod_s1;
			trig_s1 <= start_trig; // R16
			trig_s2 <= trig_s1;
			trig_s3 <= trig_s2;
		end
	end
	// Edge of the trigger, past the synchroniser
	assign trig_rise = trig_s2 && !trig_s3; // R16

	// Configuration registers
	always_comb begin
		next_mode = mode;
		next_res8 = res8;
		next_clkdiv = clkdiv;
		if (wr_acc && (paddr == `DSQ_OFF_CTRL)) begin
			// Mode select R1
			next_mode = dsq_pkg::dsq_mode_t'(pwdata[`DSQ_CTRL_MODE_HI:`DSQ_CTRL_MODE_LO]);
			// Resolution select R13
			next_res8 = pwdata[`DSQ_CTRL_RES8];
		end
		if (wr_acc && (paddr == `DSQ_OFF_CLKDIV)) begin
			next_clkdiv = pwdata[7:0];
		end
	end

	// Register configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= dsq_pkg::dsq_mode_t'(`DSQ_RST_MODE);
			res8 <= 1'b0;
			clkdiv <= `DSQ_RST_CLKDIV;
		end else begin
			mode <= next_mode;
			res8 <= next_res8;
			clkdiv <= next_clkdiv;
		end
	end

	// Modulator tick divider, runs only while converting
	always_comb begin
		next_div_cnt = div_cnt;
		if (state != dsq_pkg::DSQ_CONV) begin
			next_div_cnt = 8'h00;
		end else if (div_cnt == 8'h00) begin
			// Turbo halves the divide ratio R1 R13
			next_div_cnt = (mode == dsq_pkg::DSQ_TURBO) ? {1'b0, clkdiv[7:1]} : clkdiv;
		end else begin
			next_div_cnt = div_cnt - 8'h01;
		end
	end
	assign tick = (state == dsq_pkg::DSQ_CONV) && (div_cnt == 8'h00);

	// Register divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end

	// Decimator
	dsq_decimator u_dec (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick),
		.mod_bit(mod_s2),
		.clear(dec_clear),
		.res8(res8),
		.conv_end(conv_end),
		.word(dec_word)
	);

	// Fourth conversion after re-prime gives a result
	assign res_event = (state == dsq_pkg::DSQ_CONV) && conv_end && (prime == `DSQ_PRIMED) && !stop_wr; // R4

	// Sequencer next state
	always_comb begin
		next_state = state;
		next_prime = prime;
		dec_clear = 1'b0;
		unique case (state)
			dsq_pkg::DSQ_IDLE: begin
				// Start by bit or trigger R2
				if (start_wr || trig_rise) begin
					next_state = dsq_pkg::DSQ_CONV;
					next_prime = 2'h0;
					dec_clear = 1'b1;
				end
			end
			dsq_pkg::DSQ_CONV: begin
				// Triggers ignored while busy R16
				if (stop_wr) begin
					next_state = dsq_pkg::DSQ_IDLE;
					dec_clear = 1'b1;
				end else if (conv_end && (prime != `DSQ_PRIMED)) begin
					// Priming conversions R5 R7
					next_prime = prime + 2'h1;
				end else if (res_event) begin
					unique case (mode)
						dsq_pkg::DSQ_SINGLE: begin
							// Stop and wait for read R5
							next_state = dsq_pkg::DSQ_HOLD;
						end
						dsq_pkg::DSQ_CONT: begin
							// Keep primed, every conversion counts R7
							next_prime = `DSQ_PRIMED;
						end
						dsq_pkg::DSQ_MULTI, dsq_pkg::DSQ_TURBO: begin
							// Re-prime and restart R9
							next_prime = 2'h0;
							dec_clear = 1'b1;
						end
					endcase
				end
			end
			dsq_pkg::DSQ_HOLD: begin
				// Back to standby once read R6
				if (rd_result || stop_wr) begin
					next_state = dsq_pkg::DSQ_IDLE;
				end
			end
			default: begin
				next_state = dsq_pkg::DSQ_IDLE;
			end
		endcase
	end

	// Register sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= dsq_pkg::DSQ_IDLE;
			prime <= 2'h0;
		end else begin
			state <= next_state;
			prime <= next_prime;
		end
	end

	// Result and completion flag
	always_comb begin
		next_result = result;
		next_done = done;
		if (res_event) begin
			// Present result and flag R3
			next_result = dec_word;
			next_done = 1'b1; // R15
		end else if (rd_result) begin
			next_done = 1'b0; // R15
		end
	end

	// Register result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result <= 12'h000;
			done <= 1'b0;
		end else begin
			result <= next_result;
			done <= next_done;
		end
	end
	// Done pin for interrupt or DMA request R3 R10 R12
	assign conv_done = done;

	// Read data captured in setup phase
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (psel && !penable) begin
			unique case (paddr)
				`DSQ_OFF_CTRL: begin
					next_prdata[`DSQ_CTRL_MODE_HI:`DSQ_CTRL_MODE_LO] = mode;
					next_prdata[`DSQ_CTRL_RES8] = res8;
				end
				`DSQ_OFF_STATUS: begin
					// Polled completion R10
					next_prdata[`DSQ_ST_DONE] = done;
					next_prdata[`DSQ_ST_BUSY] = (state != dsq_pkg::DSQ_IDLE);
					next_prdata[`DSQ_ST_PRIME_HI:`DSQ_ST_PRIME_LO] = prime;
				end
				`DSQ_OFF_RESULT: begin
					next_prdata[11:0] = result;
				end
				`DSQ_OFF_CLKDIV: begin
					next_prdata[7:0] = clkdiv;
				end
				default: begin
					next_pslverr = 1'b1;
				end
			endcase
		end else if (psel && penable) begin
			next_prdata = prdata;
			next_pslverr = pslverr;
		end
	end

	// Register bus answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	start_seq_a: assert property ((state == dsq_pkg::DSQ_IDLE) && start_wr |=> // R2
		(state == dsq_pkg::DSQ_CONV) && (prime == 2'h0)) else $error("start not taken");
	done_set_a: assert property (res_event |=> conv_done && (result == $past(dec_word))) // R3
		else $error("result not presented");
	prime_a: assert property ((state == dsq_pkg::DSQ_CONV) && conv_end && (prime != `DSQ_PRIMED) // R4
		&& !stop_wr |=> (!conv_done || $past(conv_done)) && $stable(result)) else $error("result during priming");
	single_hold_a: assert property (res_event && (mode == dsq_pkg::DSQ_SINGLE) |=> // R5
		(state == dsq_pkg::DSQ_HOLD) && !tick) else $error("single did not stop");
	hold_exit_a: assert property ((state == dsq_pkg::DSQ_HOLD) && rd_result |=> // R6
		(state == dsq_pkg::DSQ_IDLE) && !conv_done) else $error("no standby after read");
	cont_run_a: assert property (res_event && (mode == dsq_pkg::DSQ_CONT) |=> // R7
		(state == dsq_pkg::DSQ_CONV) && (prime == `DSQ_PRIMED)) else $error("continuous lost priming");
	multi_reprime_a: assert property (res_event && (mode == dsq_pkg::DSQ_MULTI) |=> // R9
		(state == dsq_pkg::DSQ_CONV) && (prime == 2'h0)) else $error("multi not re-primed");
	read_clear_a: assert property (rd_result && !res_event |=> !conv_done) // R15
		else $error("read did not clear done");
	set_wins_a: assert property (rd_result && res_event |=> conv_done) // R15
		else $error("clear beat set");
	trig_busy_a: assert property ((state == dsq_pkg::DSQ_HOLD) && trig_rise && !rd_result && !stop_wr // R16
		|=> state == dsq_pkg::DSQ_HOLD) else $error("trigger not ignored");
	trig_sync_a: assert property ((state == dsq_pkg::DSQ_IDLE) && $rose(start_trig) && !start_wr // R16
		|=> ##1 state == dsq_pkg::DSQ_IDLE) else $error("trigger not synchronised");

	single_c: cover property ((state == dsq_pkg::DSQ_HOLD) ##1 (state == dsq_pkg::DSQ_IDLE));
	multi_c: cover property (res_event && (mode == dsq_pkg::DSQ_MULTI));
	cont_c: cover property (res_event && (mode == dsq_pkg::DSQ_CONT) ##[1:300] res_event);
	race_c: cover property (rd_result && res_event);
endmodule

// ---- test/dsq_apb_host.sv ----
// APB host model for the CPU or DMA reader
`timescale 1ns/1ps
`include "dsq_map.svh"
module dsq_apb_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req,
	input wire logic [11:0] addr,
	input wire logic wr,
	input wire logic [31:0] wdata,
	input wire logic auto_rd,
	input wire logic conv_done,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic ack,
	output logic [31:0] rdata,
	output logic slverr,
	output logic [7:0] dma_cnt
);
	logic [1:0] st; // 0 idle, 1 setup, 2 access
	logic [1:0] gap; // Quiet cycles while done clears
	logic dma; // Transfer launched by done
	// Bus sequencing, changes right after the edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{psel, penable, pwrite, ack, slverr, dma} <= 6'h00;
			{st, gap} <= 4'h0;
			paddr <= 12'h000;
			pwdata <= 32'h00000000;
			rdata <= 32'h00000000;
			dma_cnt <= 8'h00;
		end else begin
			ack <= 1'b0;
			case (st)
				2'h0: begin
					// Test request first, then done as a DMA request
					if (gap != 2'h0) begin
						gap <= gap - 2'h1;
					end else if (req) begin
						{psel, pwrite, dma, st} <= {1'b1, wr, 1'b0, 2'h1};
						paddr <= addr;
						pwdata <= wdata;
					end else if (auto_rd && conv_done) begin
						{psel, pwrite, dma, st} <= {1'b1, 1'b0, 1'b1, 2'h1};
						paddr <= `DSQ_OFF_RESULT;
					end
				end
				2'h1: begin
					penable <= 1'b1;
					st <= 2'h2;
				end
				default: begin
					// Take the answer only when ready is seen
					if (pready) begin
						rdata <= prdata;
						slverr <= pslverr;
						{psel, penable, st, gap} <= {4'h0, 2'h2};
						paddr <= ~paddr;
						pwdata <= ~pwdata;
						ack <= !dma;
						dma_cnt <= dma_cnt + {7'h00, dma};
					end
				end
			endcase
		end
	end
endmodule

// ---- test/delta_sigma_adc_conversion_sequencer_tb.sv ----
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`include "dsq_map.svh"
module delta_sigma_adc_conversion_sequencer_tb;
	logic pclk, presetn, req, wr, auto_rd, mod_bit_in, start_trig, conv_done;
	logic psel, penable, pwrite, pready, pslverr, ack, slverr;
	logic [11:0] paddr, addr;
	logic [31:0] pwdata, prdata, wdata, rdata;
	logic [7:0] dma_cnt;
	int miscompares, checks_done, cyc, n;
	dsq_sequencer dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mod_bit_in(mod_bit_in), .start_trig(start_trig), .conv_done(conv_done));
	dsq_apb_host host_u (.pclk(pclk), .presetn(presetn), .req(req), .addr(addr), .wr(wr), .wdata(wdata),
		.auto_rd(auto_rd), .conv_done(conv_done), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .ack(ack),
		.rdata(rdata), .slverr(slverr), .dma_cnt(dma_cnt));
	// Clock, 50 ns period
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Verdict and end of run
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// One APB transfer through the host model
	task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		{req, wr} <= {1'b1, w};
		addr <= a;
		wdata <= d;
		do @(posedge pclk); while (ack !== 1'b1);
		req <= 1'b0;
	endtask
	// Control word, 8-bit resolution always
	function automatic logic [31:0] ctl(input dsq_pkg::dsq_mode_t m, input logic go, input logic halt);
		return {27'h0, halt, go, 1'b1, m};
	endfunction
	// Cycles until done, bounded
	task automatic wait_done(input int lim);
		n = 0;
		while (conv_done !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
		chk("done_wait", {31'h0, conv_done}, 32'h1);
	endtask
	// Reset values, access kinds, unmapped place
	task automatic t_regs;
		chk("done_rst", {31'h0, conv_done}, 32'h0);
		chk("pready", {31'h0, pready}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			bus(12'(4 * i), 1'b0, 32'h0);
			chk("reg_rst", rdata, 32'h0);
		end
		bus(`DSQ_OFF_CLKDIV, 1'b1, 32'h000001a5);
		bus(`DSQ_OFF_CLKDIV, 1'b0, 32'h0);
		chk("clkdiv", rdata, 32'h000000a5);
		bus(`DSQ_OFF_CLKDIV, 1'b1, 32'h0);
		bus(`DSQ_OFF_STATUS, 1'b1, 32'h0000000f);
		bus(`DSQ_OFF_STATUS, 1'b0, 32'h0);
		chk("status_ro", rdata, 32'h0);
		bus(12'h010, 1'b0, 32'h0);
		chk("unmapped", {31'h0, slverr}, 32'h1);
		$display("test regs done");
	endtask
	// Single sample from start bit, restart ignored
	task automatic t_single;
		int t;
		mod_bit_in <= 1'b1;
		bus(`DSQ_OFF_CTRL, 1'b1, ctl(dsq_pkg::DSQ_SINGLE, 1'b1, 1'b0));
		repeat (400) @(posedge pclk);
		bus(`DSQ_OFF_CTRL, 1'b1, ctl(dsq_pkg::DSQ_SINGLE, 1'b1, 1'b0));
		wait_done(800);
		t = n + 403;
		chk("single_lat", 32'(t >= 1000 && t <= 1040), 32'h1);
		// Trigger edge while holding must be ignored
		start_trig <= 1'b1;
		repeat (6) @(posedge pclk);
		start_trig <= 1'b0;
		bus(`DSQ_OFF_STATUS, 1'b0, 32'h0);
		chk("status_done", rdata & 32'h3, 32'h3);
		chk("done_held", {31'h0, conv_done}, 32'h1);
		bus(`DSQ_OFF_RESULT, 1'b0, 32'h0);
		chk("result_full", rdata, {24'h0, `DSQ_MAX8});
		chk("done_clear", {31'h0, conv_done}, 32'h0);
		bus(`DSQ_OFF_STATUS, 1'b0, 32'h0);
		chk("standby", rdata & 32'h3, 32'h0);
		$display("test single done");
	endtask
	// Single sample from trigger pin, level ignored
	task automatic t_trig;
		mod_bit_in <= 1'b0;
		repeat (8) @(posedge pclk);
		start_trig <= 1'b1;
		wait_done(1100);
		chk("trig_lat", 32'(n >= 1000 && n <= 1045), 32'h1);
		bus(`DSQ_OFF_RESULT, 1'b0, 32'h0);
		chk("result_zero", rdata, 32'h0);
		repeat (50) @(posedge pclk);
		bus(`DSQ_OFF_STATUS, 1'b0, 32'h0);
		chk("trig_level", rdata & 32'h3, 32'h0);
		start_trig <= 1'b0;
		$display("test trigger done");
	endtask
	// Continuous: primed latency, then a result each conversion read by DMA
	task automatic t_cont;
		mod_bit_in <= 1'b1;
		bus(`DSQ_OFF_CTRL, 1'b1, ctl(dsq_pkg::DSQ_CONT, 1'b1, 1'b0));
		wait_done(1100);
		chk("cont_lat", 32'(n >= 1000 && n <= 1040), 32'h1);
		auto_rd <= 1'b1;
		repeat (1030) @(posedge pclk);
		chk("cont_rate", 32'(dma_cnt >= 8'h4 && dma_cnt <= 8'h5), 32'h1);
		auto_rd <= 1'b0;
		bus(`DSQ_OFF_CTRL, 1'b1, ctl(dsq_pkg::DSQ_CONT, 1'b0, 1'b1));
		bus(`DSQ_OFF_STATUS, 1'b0, 32'h0);
		chk("cont_stop", rdata & 32'h2, 32'h0);
		$display("test continuous done");
	endtask
	// Single sample at 12-bit resolution, four long conversions
	task automatic t_res12;
		bus(`DSQ_OFF_CTRL, 1'b1, 32'h00000008);
		wait_done(16500);
		chk("res12_lat", 32'(n >= 16380 && n <= 16400), 32'h1);
		bus(`DSQ_OFF_RESULT, 1'b0, 32'h0);
		chk("result_12", rdata, {20'h0, `DSQ_MAX12});
		$display("test resolution done");
	endtask
	// Multi and turbo: re-prime before each later result
	task automatic t_multi;
		dsq_pkg::dsq_mode_t m;
		// Tick every second cycle; turbo halves the ratio to every cycle
		bus(`DSQ_OFF_CLKDIV, 1'b1, 32'h00000001);
		for (int i = 0; i < 2; i++) begin
			m = i ? dsq_pkg::DSQ_TURBO : dsq_pkg::DSQ_MULTI;
			bus(`DSQ_OFF_CTRL, 1'b1, ctl(m, 1'b1, 1'b0));
			wait_done(2200);
			bus(`DSQ_OFF_RESULT, 1'b0, 32'h0);
			chk("multi_res", rdata, {24'h0, `DSQ_MAX8});
			wait_done(2200);
			chk("multi_reprime", 32'(i ? (n >= 1010 && n <= 1030) : (n >= 2030 && n <= 2055)), 32'h1);
			bus(`DSQ_OFF_CTRL, 1'b1, ctl(m, 1'b0, 1'b1));
			bus(`DSQ_OFF_RESULT, 1'b0, 32'h0);
		end
		$display("test multi done");
	endtask
	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			final_report;
		end
	end
	// Main sequence
	initial begin
		miscompares = 0;
		checks_done = 0;
		cyc = 0;
		{presetn, req, wr, auto_rd, mod_bit_in, start_trig} = 6'h00;
		addr = 12'h000;
		wdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_single;
		t_trig;
		t_cont;
		t_res12;
		t_multi;
		final_report;
	end
endmodule
